// ==== dic_defs.svh ====
// Register offsets, field positions, source codes and timing counts for the input conditioning block.
// Assumes a 100 MHz system clock and a byte-addressed plain register port.
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH

`define DIC_SYS_CLK_HZ 100000000
`define DIC_SAMPLE_PERIOD_US 1000
`define DIC_SAMPLE_CYCLES ((`DIC_SYS_CLK_HZ / 1000000) * `DIC_SAMPLE_PERIOD_US)

`define DIC_ADDR_SPECIAL_FUNCTION_MASK 8'h00
`define DIC_ADDR_INPUT_POLARITY_MASK 8'h04
`define DIC_ADDR_INPUT_OVERRIDE_MASK 8'h08
`define DIC_ADDR_INPUT_OVERRIDE_VALUE 8'h0c
`define DIC_ADDR_RAW_INPUT_LEVELS 8'h10
`define DIC_ADDR_THRESHOLD_SELECT 8'h14
`define DIC_ADDR_PAIR_MODE_SELECT 8'h18
`define DIC_ADDR_INPUT_REMAP_ENABLE 8'h1c
`define DIC_ADDR_INPUT_SUMMARY_WORD 8'h20
`define DIC_ADDR_SOURCE_TABLE_BASE 8'h80

`define DIC_SPECIAL_BITS 4
`define DIC_LEVEL_BIT_BASE 16
`define DIC_SRC_ZERO 7'h00
`define DIC_SRC_INPUT_LAST 7'h10
`define DIC_SRC_HALL_U 7'h41
`define DIC_SRC_ENC_A 7'h44
`define DIC_SRC_USB_POWER 7'h47
`define DIC_SRC_INVERT_BIT 7

`endif

// ==== dic_pkg.sv ====
// Types shared by the input conditioning block.
// Assumes the constants header is included by users of the numbers.
package dic_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dic_bus_req_t;

    typedef struct packed {
        logic [2:0] hall;
        logic [2:0] enc;
        logic usb_power;
    } dic_aux_t;

endpackage

// ==== dic_input_cond.sv ====
// Digital input conditioning: millisecond sampling, forcing, inversion, special-function gating and routing.
// Assumes pins are asynchronous to sys_clk and registers are reached over a plain strobe port.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.svh"

module dic_input_cond #(
    parameter int NUM_INPUTS = 16,
    parameter int SAMPLE_CYCLES = `DIC_SAMPLE_CYCLES,
    parameter int CLKDIR_FIRST = 3,
    parameter int CLKDIR_LAST = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input var dic_pkg::dic_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Input pins, positive and negative halves of each pair
    input wire logic [NUM_INPUTS-1:0] in_pos_pin,
    input wire logic [NUM_INPUTS-1:0] in_neg_pin,
    input var dic_pkg::dic_aux_t aux_pin,
    // Analog front-end controls and results
    output logic threshold_24v,
    output logic pair_differential,
    output logic interlock_fault
);

    localparam int CW = $clog2(SAMPLE_CYCLES + 1);
    localparam int AUXW = 7;

    logic [NUM_INPUTS-1:0] pos_s1_reg, pos_s2_reg, neg_s1_reg, neg_s2_reg;
    logic [AUXW-1:0] aux_s1_reg, aux_s2_reg;
    logic [CW-1:0] tick_cnt_reg;
    logic tick;
    logic [NUM_INPUTS-1:0] raw_reg;
    logic [AUXW-1:0] aux_raw_reg;
    logic [31:0] special_mask_reg, polarity_reg, ovr_mask_reg, ovr_value_reg;
    logic threshold_reg, pair_mode_reg, remap_en_reg;
    logic [7:0] src_table_reg [32];
    logic [31:0] summary_reg;
    logic [31:0] summary_next;
    logic [NUM_INPUTS-1:0] cond_level;
    logic [NUM_INPUTS-1:0] live_level;
    logic [NUM_INPUTS-1:0] clkdir_mask;
    logic [31:0] rdata_next;
    logic table_sel;
    logic [4:0] table_idx;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_s1_reg <= '0;
            pos_s2_reg <= '0;
        end else begin
            pos_s1_reg <= in_pos_pin;
            pos_s2_reg <= pos_s1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_s1_reg <= '0;
            neg_s2_reg <= '0;
        end else begin
            neg_s1_reg <= in_neg_pin;
            neg_s2_reg <= neg_s1_reg;
        end
    end

    // Auxiliary lines are stored Hall U, V, W, encoder A, B, index, then USB power from bit 0 up.
    // That order lets a source code minus the first auxiliary code index them directly.
    // auxiliary source order
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_s1_reg <= '0;
            aux_s2_reg <= '0;
        end else begin
            aux_s1_reg <= {aux_pin.usb_power, aux_pin.enc, aux_pin.hall};
            aux_s2_reg <= aux_s1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
        end else if (tick_cnt_reg == CW'(SAMPLE_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + CW'(1);
        end
    end

    assign tick = (tick_cnt_reg == CW'(SAMPLE_CYCLES - 1));

    // Pairs that can run differentially read high when positive exceeds negative.
    // one select for all pairs
    always_comb begin
        live_level = pos_s2_reg;
        if (pair_mode_reg) begin
            for (int i = CLKDIR_FIRST - 1; i < CLKDIR_LAST; i++) begin
                live_level[i] = pos_s2_reg[i] & ~neg_s2_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_reg <= '0;
            aux_raw_reg <= '0;
        end else if (tick) begin
            raw_reg <= live_level;
            aux_raw_reg <= aux_s2_reg;
        end
    end

    // Clock and direction bits 4 to 7 keep their raw sense whatever the polarity mask says; bits 2 and 3 follow it.
    always_comb begin
        clkdir_mask = '0;
        for (int i = CLKDIR_FIRST + 1; i < CLKDIR_LAST; i++) begin
            clkdir_mask[i] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : g_cond
            logic forced;
            assign forced = ovr_mask_reg[g] ? ovr_value_reg[g] : raw_reg[g];
            assign cond_level[g] = forced ^ (polarity_reg[g] & ~clkdir_mask[g]);
        end
    endgenerate

    function automatic logic pick_source(input logic [7:0] code, input logic [NUM_INPUTS-1:0] lv,
                                         input logic [AUXW-1:0] aux);
        logic base;
        logic [6:0] c;
        base = 1'b0;
        c = code[6:0];
        if (c >= 7'h01 && c <= `DIC_SRC_INPUT_LAST) begin
            base = lv[4'(c - 7'h01)];
        end else if (c >= `DIC_SRC_HALL_U && c <= `DIC_SRC_USB_POWER) begin
            base = aux[3'(c - `DIC_SRC_HALL_U)];
        end
        return base ^ code[`DIC_SRC_INVERT_BIT];
    endfunction

    always_comb begin
        summary_next = '0;
        if (remap_en_reg) begin
            for (int b = 0; b < 32; b++) begin
                summary_next[b] = pick_source(src_table_reg[b], cond_level, aux_raw_reg);
            end
        end else begin
            summary_next[`DIC_SPECIAL_BITS-1:0] = cond_level[`DIC_SPECIAL_BITS-1:0];
            summary_next[`DIC_LEVEL_BIT_BASE +: NUM_INPUTS] = cond_level;
        end
        summary_next[`DIC_SPECIAL_BITS-1:0] = summary_next[`DIC_SPECIAL_BITS-1:0]
                                             & special_mask_reg[`DIC_SPECIAL_BITS-1:0];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_reg <= '0;
        end else begin
            summary_reg <= summary_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interlock_fault <= 1'b0;
        end else begin
            interlock_fault <= special_mask_reg[3] & ~summary_next[3];
        end
    end

    assign table_sel = (bus_req.addr[7] == 1'b1);
    assign table_idx = bus_req.addr[6:2];

    // Control registers written by software, one block per register, except the remap enable and source table, which share one.
    // special-function mask
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            special_mask_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_SPECIAL_FUNCTION_MASK) begin
            special_mask_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            polarity_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_INPUT_POLARITY_MASK) begin
            polarity_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_mask_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_INPUT_OVERRIDE_MASK) begin
            ovr_mask_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_value_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_INPUT_OVERRIDE_VALUE) begin
            ovr_value_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold_reg <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_THRESHOLD_SELECT) begin
            threshold_reg <= bus_req.wdata[0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pair_mode_reg <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_PAIR_MODE_SELECT) begin
            pair_mode_reg <= bus_req.wdata[0];
        end
    end

    // Toggling the mode reloads the table each time, which is why software is told not to.
    // repeated toggling discards table
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remap_en_reg <= 1'b0;
            for (int k = 0; k < 32; k++) begin
                src_table_reg[k] <= 8'h00;
            end
        end else if (bus_req.wr && bus_req.addr == `DIC_ADDR_INPUT_REMAP_ENABLE) begin
            remap_en_reg <= bus_req.wdata[0];
            if (bus_req.wdata[0] && !remap_en_reg) begin
                for (int k = 0; k < 32; k++) begin
                    if (k < `DIC_SPECIAL_BITS) begin
                        src_table_reg[k] <= 8'(k + 1);
                    end else if (k >= `DIC_LEVEL_BIT_BASE && k < `DIC_LEVEL_BIT_BASE + NUM_INPUTS) begin
                        src_table_reg[k] <= 8'(k - `DIC_LEVEL_BIT_BASE + 1);
                    end else begin
                        src_table_reg[k] <= 8'h00;
                    end
                end
            end
        end else if (bus_req.wr && table_sel) begin
            src_table_reg[table_idx] <= bus_req.wdata[7:0];
        end
    end

    always_comb begin
        rdata_next = '0;
        if (table_sel) begin
            rdata_next = {24'h000000, src_table_reg[table_idx]};
        end else begin
            unique case (bus_req.addr)
                `DIC_ADDR_SPECIAL_FUNCTION_MASK: rdata_next = special_mask_reg;
                `DIC_ADDR_INPUT_POLARITY_MASK: rdata_next = polarity_reg;
                `DIC_ADDR_INPUT_OVERRIDE_MASK: rdata_next = ovr_mask_reg;
                `DIC_ADDR_INPUT_OVERRIDE_VALUE: rdata_next = ovr_value_reg;
                `DIC_ADDR_RAW_INPUT_LEVELS: rdata_next = 32'(raw_reg);
                `DIC_ADDR_THRESHOLD_SELECT: rdata_next = {31'h0, threshold_reg};
                `DIC_ADDR_PAIR_MODE_SELECT: rdata_next = {31'h0, pair_mode_reg};
                `DIC_ADDR_INPUT_REMAP_ENABLE: rdata_next = {31'h0, remap_en_reg};
                `DIC_ADDR_INPUT_SUMMARY_WORD: rdata_next = summary_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= '0;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_next;
        end else begin
            bus_rdata <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold_24v <= 1'b0;
            pair_differential <= 1'b0;
        end else begin
            threshold_24v <= threshold_reg;
            pair_differential <= pair_mode_reg;
        end
    end

endmodule

`default_nettype wire

// ==== dic_input_cond_props.sv ====
// Checker for the input conditioning block: readback, mode gating and output relations.
// Assumes the block's byte offsets and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module dic_input_cond_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input var dic_pkg::dic_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // Front-end and fault outputs
    input wire logic threshold_24v,
    input wire logic pair_differential,
    input wire logic interlock_fault
);
    logic [3:0] spec_sh;
    logic remap_sh;
    logic thr_sh;
    logic pair_sh;
    logic [1:0] quiet;
    logic rd20;
    assign rd20 = bus_req.rd && bus_req.addr == 8'h20;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // The settle counter keeps the summary checks away from special-mask and remap-enable writes still in flight.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_sh <= 4'h0;
            remap_sh <= 1'b0;
            thr_sh <= 1'b0;
            pair_sh <= 1'b0;
            quiet <= 2'h0;
        end else begin
            if (bus_req.wr && bus_req.addr == 8'h00) spec_sh <= bus_req.wdata[3:0];
            if (bus_req.wr && bus_req.addr == 8'h1c) remap_sh <= bus_req.wdata[0];
            if (bus_req.wr && bus_req.addr == 8'h14) thr_sh <= bus_req.wdata[0];
            if (bus_req.wr && bus_req.addr == 8'h18) pair_sh <= bus_req.wdata[0];
            if (bus_req.wr && (bus_req.addr == 8'h00 || bus_req.addr == 8'h1c)) quiet <= 2'h0;
            else if (quiet != 2'h3) quiet <= quiet + 2'h1;
        end
    end
    property p_thr;
        $past(thr_sh) == thr_sh && $past(thr_sh, 2) == thr_sh |-> threshold_24v == thr_sh;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold output lost");
    property p_pair;
        $past(pair_sh) == pair_sh && $past(pair_sh, 2) == pair_sh |-> pair_differential == pair_sh;
    endproperty
    a_pair: assert property (p_pair) else $error("pair mode output lost");
    property p_ilk_ok;
        $past(rd20) && bus_rdata[3] |-> !$past(interlock_fault);
    endproperty
    a_ilk_ok: assert property (p_ilk_ok) else $error("fault with release set");
    property p_ilk_bad;
        $past(rd20 && spec_sh[3] && quiet == 2'h3) && !bus_rdata[3] |-> $past(interlock_fault);
    endproperty
    a_ilk_bad: assert property (p_ilk_bad) else $error("no fault with release clear");
    property p_mid;
        $past(rd20 && !remap_sh && quiet == 2'h3) |-> bus_rdata[15:4] == 12'h000;
    endproperty
    a_mid: assert property (p_mid) else $error("fixed summary middle bits set");
    property p_low;
        $past(rd20 && !remap_sh && quiet == 2'h3) |-> bus_rdata[3:0] == (bus_rdata[19:16] & spec_sh);
    endproperty
    a_low: assert property (p_low) else $error("special bits disagree with levels");
    property p_spec_rb;
        bus_req.rd && bus_req.addr == 8'h00 |=> bus_rdata[3:0] == spec_sh;
    endproperty
    a_spec_rb: assert property (p_spec_rb) else $error("special mask readback wrong");
    property p_remap_rb;
        bus_req.rd && bus_req.addr == 8'h1c |=> bus_rdata[0] == remap_sh;
    endproperty
    a_remap_rb: assert property (p_remap_rb) else $error("remap enable readback wrong");
endmodule
bind dic_input_cond dic_input_cond_props dic_input_cond_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .threshold_24v(threshold_24v),
    .pair_differential(pair_differential), .interlock_fault(interlock_fault));
`default_nettype wire

// ==== dic_switch_model.sv ====
// Model of the switches and line drivers wired to the input pins.
// Assumes the bench commands levels just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dic_switch_model (
    // Clock and receiver mode
    input wire logic sys_clk,
    input wire logic pair_differential,
    // Commanded levels
    input wire logic [15:0] level,
    input wire logic [15:0] flip,
    // Pins
    output logic [15:0] pos_pin,
    output logic [15:0] neg_pin
);
    logic churn = 1'b0;
    always @(posedge sys_clk) begin
        churn <= !churn;
    end
    assign pos_pin = level;
    // pair drive
    // Negative halves churn while the pairs are single-ended, so a receiver that reads them shows it.
    assign neg_pin = pair_differential ? (~level ^ flip) : {16{churn}};
endmodule
`default_nettype wire

// ==== test_digital_input_conditioning.sv ====
// Bench for the input conditioning block: random configurations in fixed and routed modes.
// Assumes the switch model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_digital_input_conditioning;
    localparam int SC = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    dic_pkg::dic_bus_req_t bus_req = '0;
    dic_pkg::dic_aux_t aux_pin = '0;
    logic [31:0] bus_rdata;
    logic [15:0] level = 16'h0000;
    logic [15:0] flip = 16'h0000;
    logic [15:0] pos_pin;
    logic [15:0] neg_pin;
    logic threshold_24v;
    logic pair_differential;
    logic interlock_fault;
    int errors = 0;
    int checks_done = 0;
    int seed = 63;
    logic [31:0] d;
    logic [15:0] c;
    logic [31:0] cfg [8];
    logic [6:0] codes [24];
    logic [7:0] tab [32];
    always #5 sys_clk = ~sys_clk;
    dic_input_cond #(.SAMPLE_CYCLES(SC)) dic_input_cond_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .in_pos_pin(pos_pin), .in_neg_pin(neg_pin),
        .aux_pin(aux_pin), .threshold_24v(threshold_24v), .pair_differential(pair_differential),
        .interlock_fault(interlock_fault));
    dic_switch_model dic_switch_model_i (.sys_clk(sys_clk), .pair_differential(pair_differential),
        .level(level), .flip(flip), .pos_pin(pos_pin), .neg_pin(neg_pin));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        if (a < 8'h20) cfg[a[4:2]] = v;
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Forcing comes before inversion, and clock and direction bits 4 to 7 are never inverted.
    function automatic logic [15:0] cond();
        logic [15:0] lv;
        lv = level;
        if (cfg[6][0]) lv[7:2] = level[7:2] & ~flip[7:2];
        return ((lv & ~cfg[2][15:0]) | (cfg[3][15:0] & cfg[2][15:0])) ^ (cfg[1][15:0] & 16'hff0f);
    endfunction
    function automatic logic [31:0] routed();
        logic [15:0] cv;
        logic [6:0] ax;
        logic [31:0] s;
        cv = cond();
        ax = {aux_pin.usb_power, aux_pin.enc, aux_pin.hall};
        for (int k = 0; k < 32; k++) begin
            s[k] = tab[k][7];
            if (tab[k][6:0] >= 7'h01 && tab[k][6:0] <= 7'h10) s[k] ^= cv[tab[k][4:0] - 5'd1];
            if (tab[k][6:0] >= 7'h41 && tab[k][6:0] <= 7'h47) s[k] ^= ax[tab[k][2:0] - 3'd1];
        end
        s[3:0] &= cfg[0][3:0];
        return s;
    endfunction
    initial begin
        #200us;
        errors++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 8; i++) cfg[i] = 32'h0;
        for (int i = 0; i < 17; i++) codes[i] = 7'(i);
        for (int i = 0; i < 7; i++) codes[17 + i] = 7'(8'h41 + i);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            rd(8'(a * 4));
            chk("reset value", d, 32'h0);
        end
        wr(8'h40, 32'hffffffff);
        rd(8'h40);
        chk("unmapped", d, 32'h0);
        @(posedge sys_clk);
        level <= 16'h8000;
        for (int t = 0; t < 20 && d[15] !== 1'b1; t++) rd(8'h10);
        @(posedge sys_clk);
        level <= 16'hc000;
        repeat (3) @(posedge sys_clk);
        level <= 16'h8000;
        repeat (2 * SC) @(posedge sys_clk);
        rd(8'h10);
        chk("short pulse", d[15:0], 16'h8000);
        for (int i = 0; i < 6; i++) begin
            for (int a = 0; a < 7; a++) if (a != 4) wr(8'(a * 4), $random(seed));
            @(posedge sys_clk);
            level <= 16'($random(seed));
            flip <= 16'($random(seed));
            repeat (2 * SC + 6) @(posedge sys_clk);
            rd(8'h10);
            c = cfg[6][0] ? 16'hff03 : 16'hffff;
            chk("raw", d[15:0] & c, level & c);
            rd(8'h20);
            c = cond();
            chk("summary", d, {c, 12'h000, c[3:0] & cfg[0][3:0]});
        end
        // Routing is switched on once and never back, so the preload runs only once.
        wr(8'h1c, 32'h1);
        for (int k = 0; k < 32; k++) begin
            rd(8'(128 + 4 * k));
            tab[k] = k < 4 ? 8'(k + 1) : (k >= 16 ? 8'(k - 15) : 8'h00);
            chk("preload", d[7:0], tab[k]);
        end
        rd(8'h20);
        chk("preload summary", d, routed());
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 32; k++) begin
                d = $random(seed);
                tab[k] = {d[0], codes[(k + 8 * r) % 24]};
                wr(8'(128 + 4 * k), {24'h0, tab[k]});
            end
            @(posedge sys_clk);
            aux_pin <= 7'($random(seed));
            level <= 16'($random(seed));
            repeat (2 * SC + 6) @(posedge sys_clk);
            rd(8'h20);
            chk("routed", d, routed());
        end
        give_verdict();
    end
endmodule
`default_nettype wire
